// file: src/delay_setting_program_port.sv
// Programming front end of an 8-bit programmable delay element.
// Assumes pins arrive asynchronously and are sampled by clk_i at 100 MHz;
// software reaches control and status over a single AHB-Lite slave port.
//
// The address map and register access over AHB-Lite were decided locally.
`include "delay_prog_cfg.svh"

module delay_setting_program_port (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Programming pins.
   input  wire logic [7:0]  setting_in_i,
   output logic             setting_in_bit0_o,
   output logic             setting_in_bit0_oe_o,
   input  wire logic        latch_enable_i,
   input  wire logic        prog_select_i,
   input  wire logic        function_select_i,
   // Setting and function towards the delay core.
   output logic [7:0]       active_setting_o,
   output logic             osc_pwm_mode_o,
   output logic             invert_output_o,
   output logic             setting_settled_o,
   // AHB-Lite slave.
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic             hreadyout_o,
   output logic             hresp_o,
   output logic [31:0]      hrdata_o
);

   localparam int SW = `DP_CTRL_SETTLE_W;

   pin_sync_if #(.WIDTH(`DP_PIN_COUNT)) pins ();

   delay_prog_pkg::setting_t   active_r;
   delay_prog_pkg::setting_t   shift_r;
   delay_prog_pkg::prog_mode_t mode_r;
   delay_prog_pkg::prog_mode_t mode_nxt;
   delay_prog_pkg::reg_sel_t   wsel_r;
   logic [7:0]                 par_bits;
   logic                       latch_lvl;
   logic                       latch_prev_r;
   logic                       sclk_prev_r;
   logic                       sclk_rise;
   logic                       latch_fall;
   logic                       func_lvl;
   logic                       dout_oe_r;
   logic                       wr_pend_r;
   logic [SW-1:0]              settle_cfg_r;
   logic [SW-1:0]              settle_cnt_r;
   logic                       settled_r;
   logic                       osc_r;
   logic                       inv_r;
   logic [31:0]                hrdata_r;
   logic                       bus_take;

   // Maps a byte address onto the register it selects.
   function automatic delay_prog_pkg::reg_sel_t reg_decode(
      input logic [31:0] addr
   );
      reg_decode = delay_prog_pkg::REG_NONE;
      if (addr[31:8] == 24'h000000) begin
         if (addr[7:0] == `DP_CTRL_OFS) begin
            reg_decode = delay_prog_pkg::REG_CTRL;
         end else if (addr[7:0] == `DP_STATUS_OFS) begin
            reg_decode = delay_prog_pkg::REG_STATUS;
         end
      end
   endfunction : reg_decode

   // Pin bundle into the synchroniser.
   assign pins.raw = {function_select_i, prog_select_i, latch_enable_i,
                      setting_in_i};

   pin_sync #(
      .WIDTH (`DP_PIN_COUNT)
   ) u_pin_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .pins  (pins)
   );

   // Clock-aligned views of the programming pins.
   assign par_bits  = pins.stable[`DP_PIN_SETTING_LSB +: 8];
   assign latch_lvl = pins.stable[`DP_PIN_LATCH];
   assign func_lvl  = pins.stable[`DP_PIN_FUNCSEL];
   assign mode_nxt  = pins.stable[`DP_PIN_PROGSEL] ?
                      delay_prog_pkg::PROG_SERIAL :
                      delay_prog_pkg::PROG_PARALLEL;

   // Edge detection on the synchronised serial clock and latch enable.
   assign sclk_rise  = pins.stable[`DP_SER_CLK_BIT] & ~sclk_prev_r;
   assign latch_fall = latch_prev_r & ~latch_lvl;

   // Edge history and programming mode.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sclk_prev_r  <= 1'b0;
         latch_prev_r <= 1'b0;
         mode_r       <= delay_prog_pkg::PROG_PARALLEL;
      end else begin
         sclk_prev_r  <= pins.stable[`DP_SER_CLK_BIT];
         latch_prev_r <= latch_lvl;
         mode_r       <= mode_nxt;
      end
   end

   // Active setting: transparent latch in parallel mode, commit on the
   // falling latch enable in serial mode.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         active_r <= `DP_SETTING_RST;
      end else begin
         unique case (mode_r)
            delay_prog_pkg::PROG_PARALLEL: begin
               if (latch_lvl) begin
                  active_r <= par_bits;
               end
            end
            delay_prog_pkg::PROG_SERIAL: begin
               if (latch_fall) begin
                  active_r <= shift_r;
               end
            end
         endcase
      end
   end

   // Shift register. In parallel mode it mirrors the latched value so a
   // later serial read-back returns the setting in force.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shift_r <= `DP_SETTING_RST;
      end else begin
         unique case (mode_r)
            delay_prog_pkg::PROG_PARALLEL: begin
               if (latch_lvl) begin
                  shift_r <= par_bits;
               end
            end
            delay_prog_pkg::PROG_SERIAL: begin
               if (latch_lvl && sclk_rise) begin
                  // MSB arrives first and moves toward the output.
                  shift_r <= {shift_r[6:0],
                              pins.stable[`DP_SER_DIN_BIT]};
               end
            end
         endcase
      end
   end

   // Serial data output shares the bit-0 pin and is driven only in
   // serial mode; it shows the stored MSB until the next shift edge.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dout_oe_r <= 1'b0;
      end else begin
         dout_oe_r <= (mode_nxt == delay_prog_pkg::PROG_SERIAL);
      end
   end

   assign setting_in_bit0_o    = shift_r[7];
   assign setting_in_bit0_oe_o = dout_oe_r;

   // Function select steers the core: high gives oscillator or pulse
   // operation with the delayed output inverted.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_r <= 1'b0;
         inv_r <= 1'b0;
      end else begin
         osc_r <= func_lvl;
         inv_r <= func_lvl;
      end
   end

   // Settling timer, restarted whenever the active setting changes, so
   // the host can see when the new delay may be relied on.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         settle_cnt_r <= SW'(`DP_SETTLE_CYCLES);
         settled_r    <= 1'b0;
      end else begin
         if ((mode_r == delay_prog_pkg::PROG_PARALLEL && latch_lvl &&
              par_bits != active_r) ||
             (mode_r == delay_prog_pkg::PROG_SERIAL && latch_fall)) begin
            settle_cnt_r <= settle_cfg_r;
            settled_r    <= 1'b0;
         end else if (settle_cnt_r != '0) begin
            settle_cnt_r <= settle_cnt_r - SW'(1);
            settled_r    <= 1'b0;
         end else begin
            settled_r    <= 1'b1;
         end
      end
   end

   assign active_setting_o  = active_r;
   assign osc_pwm_mode_o    = osc_r;
   assign invert_output_o   = inv_r;
   assign setting_settled_o = settled_r;

   // Bus address phase accepted.
   assign bus_take = hsel_i & htrans_i[1] & hready_i;

   // Address phase capture; read data is prepared for the data phase.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_pend_r <= 1'b0;
         wsel_r    <= delay_prog_pkg::REG_NONE;
         hrdata_r  <= 32'h00000000;
      end else begin
         wr_pend_r <= bus_take & hwrite_i;
         wsel_r    <= reg_decode(haddr_i);
         if (bus_take && !hwrite_i) begin
            unique case (reg_decode(haddr_i))
               delay_prog_pkg::REG_CTRL: begin
                  hrdata_r <= {{(32-SW){1'b0}}, settle_cfg_r};
               end
               delay_prog_pkg::REG_STATUS: begin
                  hrdata_r <= {12'h000,
                               settled_r,
                               func_lvl,
                               latch_lvl,
                               (mode_r == delay_prog_pkg::PROG_SERIAL),
                               shift_r,
                               active_r};
               end
               default: begin
                  hrdata_r <= 32'h00000000;
               end
            endcase
         end
      end
   end

   // Control register write in the data phase.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         settle_cfg_r <= SW'(`DP_SETTLE_CYCLES);
      end else if (wr_pend_r && wsel_r == delay_prog_pkg::REG_CTRL) begin
         settle_cfg_r <= hwdata_i[`DP_CTRL_SETTLE_LSB +: SW];
      end
   end

   // Zero wait states and always an OKAY response.
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;
   assign hrdata_o    = hrdata_r;

endmodule : delay_setting_program_port

// file: common/delay_prog_cfg.svh
// Constants of the delay setting programming port: offsets, field
// positions, reset values and timing counts.
// Assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus.
`ifndef DELAY_PROG_CFG_SVH
`define DELAY_PROG_CFG_SVH

// Clock period of clk_i in ns.
`define DP_CLK_PERIOD_NS   10
// Default settling interval in ns; software may change it at run time.
`define DP_SETTLE_TIME_NS  100
// Settling interval in clock cycles, a least time rounded up.
`define DP_SETTLE_CYCLES \
   ((`DP_SETTLE_TIME_NS + `DP_CLK_PERIOD_NS - 1) / `DP_CLK_PERIOD_NS)

// Register byte offsets.
`define DP_CTRL_OFS        8'h00
`define DP_STATUS_OFS      8'h04

// Control register fields.
`define DP_CTRL_SETTLE_LSB 0
`define DP_CTRL_SETTLE_W   16

// Status register fields.
`define DP_ST_ACTIVE_LSB   0
`define DP_ST_SHIFT_LSB    8
`define DP_ST_SERIAL_BIT   16
`define DP_ST_LATCH_BIT    17
`define DP_ST_FUNC_BIT     18
`define DP_ST_SETTLED_BIT  19

// Reset values.
`define DP_SETTING_RST     8'h00

// Positions inside the synchronised pin bundle.
`define DP_PIN_SETTING_LSB 0
`define DP_PIN_LATCH       8
`define DP_PIN_PROGSEL     9
`define DP_PIN_FUNCSEL     10
`define DP_PIN_COUNT       11

// Parallel pins that double as serial lines.
`define DP_SER_DOUT_BIT    0
`define DP_SER_CLK_BIT     1
`define DP_SER_DIN_BIT     2

`endif

// file: common/delay_prog_pkg.sv
// Types of the delay setting programming port.
// Assumes delay_prog_cfg.svh is available for the constants.
package delay_prog_pkg;

   // Programming source picked by the select pin.
   typedef enum logic {
      PROG_PARALLEL,
      PROG_SERIAL
   } prog_mode_t;

   // Register selected by a bus address.
   typedef enum logic [1:0] {
      REG_CTRL,
      REG_STATUS,
      REG_NONE
   } reg_sel_t;

   // One delay setting of 256 steps.
   typedef logic [7:0] setting_t;

endpackage : delay_prog_pkg

// file: common/pin_sync_if.sv
// Bundle carrying raw pin levels into the synchroniser and the
// debounced, clock-aligned levels back out.
// Assumes both ends run on the same clk_i.
interface pin_sync_if #(
   parameter int WIDTH = 11
);
   logic [WIDTH-1:0] raw;
   logic [WIDTH-1:0] stable;

   modport sync (input raw, output stable);
   modport user (output raw, input stable);
endinterface : pin_sync_if

// file: src/pin_sync.sv
// Three-stage synchroniser for a group of asynchronous pins.
// Assumes the pins are stable for several clk_i periods around a change.
module pin_sync #(
   parameter int WIDTH = 11
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   pin_sync_if.sync  pins
);
   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;
   logic [WIDTH-1:0] stable_r;

   // Shift chain; the first stage feeds only the second.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= pins.raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // A bit changes only once the second and third stages agree.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stable_r <= '0;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               stable_r[i] <= s3_r[i];
            end
         end
      end
   end

   assign pins.stable = stable_r;
endmodule : pin_sync

// file: verif/prog_port_asserts.sv
// Checker of the programming port: pin to setting timing and bus answer.
// Assumes it is bound to delay_setting_program_port and sees its ports.
module prog_port_asserts (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [7:0] setting_in_i,
   input  wire logic       latch_enable_i,
   input  wire logic       prog_select_i,
   input  wire logic       function_select_i,
   input  wire logic [7:0] active_setting_o,
   input  wire logic       osc_pwm_mode_o,
   input  wire logic       invert_output_o,
   input  wire logic       setting_in_bit0_o,
   input  wire logic       setting_in_bit0_oe_o,
   input  wire logic       hreadyout_o,
   input  wire logic       hresp_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // All checks run on the system clock; seven cycles cover the pin sync.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_par_follow: assert property (
      ($stable(setting_in_i) && latch_enable_i && !prog_select_i)[*7]
      |=> active_setting_o == $past(setting_in_i))
      else $error("parallel setting not followed");
   chk_le_low_hold: assert property (
      (!latch_enable_i && $stable(prog_select_i))[*7]
      |=> $stable(active_setting_o))
      else $error("setting moved while latch enable low");
   chk_ser_hold: assert property (
      (latch_enable_i && prog_select_i)[*7] |=> $stable(active_setting_o))
      else $error("setting moved during serial shift");
   chk_oe_mode: assert property (
      $stable(prog_select_i)[*7]
      |=> setting_in_bit0_oe_o == $past(prog_select_i))
      else $error("serial output enable wrong");
   chk_func_mode: assert property (
      $stable(function_select_i)[*7]
      |=> osc_pwm_mode_o == $past(function_select_i))
      else $error("function mode wrong");
   chk_invert_out: assert property (
      $stable(function_select_i)[*7]
      |=> invert_output_o == $past(function_select_i))
      else $error("output inversion wrong");
   chk_shift_out: assert property (
      ($stable(setting_in_i[1]) && prog_select_i)[*7]
      |=> $stable(setting_in_bit0_o))
      else $error("serial output moved without a clock");
   chk_bus_okay: assert property (hreadyout_o && !hresp_o)
      else $error("bus answer not ready and okay");
endmodule : prog_port_asserts

bind delay_setting_program_port prog_port_asserts u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .setting_in_i(setting_in_i),
   .latch_enable_i(latch_enable_i), .prog_select_i(prog_select_i),
   .function_select_i(function_select_i),
   .active_setting_o(active_setting_o), .osc_pwm_mode_o(osc_pwm_mode_o),
   .invert_output_o(invert_output_o),
   .setting_in_bit0_o(setting_in_bit0_o),
   .setting_in_bit0_oe_o(setting_in_bit0_oe_o),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o));

// file: verif/host_model.sv
// Host that drives the parallel pins or the three-wire serial lines.
// Assumes the serial clock idles low and the design samples it on clk_i.
module host_model (
   input  wire logic       clk_i,
   input  wire logic       ser_out_i,
   output logic [7:0]      pins_o,
   output logic            latch_enable_o,
   output logic            prog_select_o,
   output logic            function_select_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Strapped start: latch enable high so the pins load at power-up.
   initial begin
      pins_o = 8'h5A;
      latch_enable_o = 1'b1;
      prog_select_o = 1'b0;
      function_select_o = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick
   task automatic set_pins(input logic [7:0] p, input logic le, ps, fs);
      pins_o <= p;
      latch_enable_o <= le;
      prog_select_o <= ps;
      function_select_o <= fs;
   endtask : set_pins
   task automatic start_frame();
      latch_enable_o <= 1'b1;
      tick(4);
   endtask : start_frame
   // Ends the frame; the data line then shows the inverse of its last bit.
   task automatic stop_frame();
      latch_enable_o <= 1'b0;
      pins_o[2] <= ~pins_o[2];
      tick(8);
   endtask : stop_frame
   // One byte, MSB first, on an 80 ns serial clock (40 ns high, 40 ns
   // low); q takes the output once the previous shift has settled.
   task automatic shift_byte(input logic [7:0] d, input logic ret,
                             output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         tick(2);
         q[i] = ser_out_i;
         pins_o[2] <= ret ? ser_out_i : d[i];
         tick(2);
         pins_o[1] <= 1'b1;
         tick(4);
         pins_o[1] <= 1'b0;
      end
   endtask : shift_byte
endmodule : host_model

// file: verif/testbench.sv
// Self-checking bench of the programming port over pins and AHB-Lite.
// Assumes delay_prog_cfg.svh offsets and a single always-ready slave.
`include "delay_prog_cfg.svh"
`define CHECK(a, b) begin n_compared++; if ((a) !== (b)) begin \
   n_errors++; $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); \
   end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i, rst_i, hsel, hwrite, hready, hresp, oe, q;
   logic        osc, inv, settled, le, ps, fs;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  host_pins, pins_w, act, b;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [7:0]  vals[4] = '{8'h00, 8'hFF, 8'h81, 8'h3C};
   int          n_errors = 0;
   int          n_compared = 0;
   // The bit0 pin carries the design's serial output while it drives.
   assign pins_w = {host_pins[7:1], oe ? q : host_pins[0]};
   delay_setting_program_port DUT (.clk_i(clk_i), .rst_i(rst_i),
      .setting_in_i(pins_w), .setting_in_bit0_o(q),
      .setting_in_bit0_oe_o(oe), .latch_enable_i(le),
      .prog_select_i(ps), .function_select_i(fs),
      .active_setting_o(act), .osc_pwm_mode_o(osc),
      .invert_output_o(inv), .setting_settled_o(settled),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
      .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
      .hrdata_o(hrdata));
   host_model host (.clk_i(clk_i), .ser_out_i(q), .pins_o(host_pins),
      .latch_enable_o(le), .prog_select_o(ps), .function_select_o(fs));
   // System clock of 10 ns.
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick
   // One bus cycle: address phase, then data phase, each until ready.
   task automatic bus(input logic [31:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      // Waits as long as the slave needs; only the watchdog ends a hang.
      do begin @(posedge clk_i); end while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do begin @(posedge clk_i); end while (hready !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic wait_settled();
      int k;
      k = 0;
      while (settled !== 1'b1 && k < 100) begin tick(1); k++; end
      `CHECK(settled, 1'b1)
   endtask : wait_settled
   task automatic end_of_test();
      $display("mismatches %0d comparisons %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test
   // Watchdog well beyond the few hundred cycles the sequence needs.
   initial begin
      #80000;
      n_errors++;
      end_of_test();
   end
   // Main sequence of pin and register tests.
   initial begin
      rst_i = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      tick(4);
      rst_i <= 1'b0;
      tick(8);
      `CHECK(act, 8'h5A)
      bus(`DP_CTRL_OFS, 1'b0, 32'h0, r);
      `CHECK(r[15:0], 16'(`DP_SETTLE_CYCLES))
      bus(32'h0000_0008, 1'b0, 32'h0, r);
      `CHECK(r, 32'h0000_0000)
      bus(`DP_CTRL_OFS, 1'b1, 32'h0000_0002, r);
      bus(`DP_CTRL_OFS, 1'b0, 32'h0, r);
      `CHECK(r[15:0], 16'h0002)
      foreach (vals[i]) begin
         host.set_pins(vals[i], 1'b1, 1'b0, 1'b0);
         tick(8);
         `CHECK(act, vals[i])
      end
      wait_settled();
      host.set_pins(8'h3C, 1'b0, 1'b0, 1'b0);
      tick(8);
      host.set_pins(8'hC3, 1'b0, 1'b0, 1'b0);
      tick(8);
      `CHECK(act, 8'h3C)
      for (int i = 1; i >= 0; i--) begin
         host.set_pins(8'hC3, 1'b0, 1'b0, i[0]);
         tick(8);
         `CHECK({osc, inv}, {i[0], i[0]})
      end
      host.set_pins(8'h00, 1'b0, 1'b1, 1'b0);
      tick(8);
      `CHECK(oe, 1'b1)
      host.start_frame();
      host.shift_byte(8'h96, 1'b0, b);
      `CHECK(act, 8'h3C)
      host.stop_frame();
      `CHECK(act, 8'h96)
      wait_settled();
      bus(`DP_STATUS_OFS, 1'b0, 32'h0, r);
      `CHECK(r[17:0], {2'b01, 8'h96, 8'h96})
      host.start_frame();
      host.shift_byte(8'h00, 1'b1, b);
      host.stop_frame();
      `CHECK(b, 8'h96)
      `CHECK(act, 8'h96)
      host.start_frame();
      host.shift_byte(8'h11, 1'b0, b);
      `CHECK(b, 8'h96)
      host.shift_byte(8'h22, 1'b0, b);
      `CHECK(b, 8'h11)
      host.stop_frame();
      `CHECK(act, 8'h22)
      host.shift_byte(8'hFF, 1'b0, b);
      bus(`DP_STATUS_OFS, 1'b0, 32'h0, r);
      `CHECK(r[15:0], 16'h2222)
      rst_i <= 1'b1;
      tick(2);
      `CHECK({act, oe}, 9'h000)
      rst_i <= 1'b0;
      tick(10);
      end_of_test();
   end
endmodule : testbench
